// file: hdl/hdlc_slot_bit_frame_select.sv
// HDLC frame parity, time slot and bit selection with channel 2/3 transmit queues
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none

// ==========================================
// Transmit queue: simple synchronous FIFO
module tx_word_queue #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 32
) (
    input  wire logic             clock,
    input  wire logic             resetn,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    // Pointer arithmetic needs a power of two
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_depth_check
        $error("tx_word_queue depth must be a power of two, at least 2");
    end

    logic [WIDTH-1:0] mem [DEPTH];   // Word storage
    logic [AW:0]      wr_ptr;        // Write pointer, extra wrap bit
    logic [AW:0]      rd_ptr;        // Read pointer, extra wrap bit
    logic [AW:0]      next_wr_ptr;
    logic [AW:0]      next_rd_ptr;
    logic             do_push;
    logic             do_pop;

    // Full when pointers differ only by the wrap bit
    assign in_ready  = !((wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]));
    assign out_valid = (wr_ptr != rd_ptr);
    assign out_data  = mem[rd_ptr[AW-1:0]];
    assign do_push   = in_valid && in_ready;
    assign do_pop    = out_valid && out_ready;

    // Pointer next values
    always_comb begin
        next_wr_ptr = do_push ? wr_ptr + 1'b1 : wr_ptr;
        next_rd_ptr = do_pop ? rd_ptr + 1'b1 : rd_ptr;
    end

    // Pointers
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
        end
    end

    // Storage has no reset; only written words are ever read
    always_ff @(posedge clock) begin
        if (do_push) begin
            mem[wr_ptr[AW-1:0]] <= in_data;
        end
    end
endmodule

// ==========================================
// Selection block
module hdlc_slot_bit_frame_select #(
    parameter int QUEUE_DEPTH = 32
) (
    input  wire logic       clock,
    input  wire logic       resetn,
    // Register port
    input  wire logic [7:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr,
    input  wire logic       rd,
    output logic      [7:0] rdata,
    // Framed line side
    input  wire logic       mf_start,      // First bit of a multiframe
    input  wire logic       fr_start,      // First bit of a frame
    input  wire logic       bit_strobe,    // One line bit this cycle
    input  wire logic [4:0] slot,          // Time slot of this bit
    input  wire logic [2:0] bit_pos,       // Bit position within the slot
    input  wire logic       line_rx_bit,   // Received line bit
    input  wire logic       ch1_tx_bit,    // Channel 1 transmit bit from its own queue
    output logic            ch1_tx_take,   // Channel 1 bit consumed this cycle
    output logic      [2:0] rx_valid,      // Per channel receive bit strobe
    output logic      [2:0] rx_data,       // Per channel receive bit
    output logic            tx_line_valid, // Transmit bit belongs to a channel
    output logic            tx_line_bit,   // Transmit bit for the line
    output logic      [1:0] queue_ready    // Channel 2/3 queues can take a word
);
    if (QUEUE_DEPTH < 2 || QUEUE_DEPTH > 256) begin : g_param_check
        $error("QUEUE_DEPTH out of range");
    end

    // ==========================================
    // Ownership decode, used for every direction and channel
    function automatic logic owns(input logic [1:0] code, input logic odd,
                                  input logic [23:0] map, input logic [4:0] s,
                                  input logic [7:0] mask, input logic [2:0] pos);
        logic parity_ok;
        logic slot_ok;
        parity_ok = (code == hdlc_sel_pkg::PARITY_ODD)  ? odd :
                    (code == hdlc_sel_pkg::PARITY_EVEN) ? !odd : 1'b1;
        slot_ok   = (s < 5'(hdlc_sel_pkg::NUM_SLOTS)) && map[s];
        return parity_ok && slot_ok && mask[pos];
    endfunction

    // ==========================================
    // Configuration registers
    logic [7:0]  frame_parity_select;   // Three parity fields
    logic [7:0]  slot_bit_mask [3];     // Per channel bit masks
    logic [23:0] transmit_slot_map;     // Channel 1 transmit slots
    logic [23:0] receive_slot_map;      // Channel 1 receive slots
    logic [23:0] slot_choice_ch2;       // Channel 2 slots, both directions
    logic [23:0] slot_choice_ch3;       // Channel 3 slots, both directions
    logic [7:0]  queue_low [2];         // Held low bytes of queue words
    logic [7:0]  next_frame_parity_select;
    logic [7:0]  next_slot_bit_mask [3];
    logic [23:0] next_transmit_slot_map;
    logic [23:0] next_receive_slot_map;
    logic [23:0] next_slot_choice_ch2;
    logic [23:0] next_slot_choice_ch3;
    logic [7:0]  next_queue_low [2];
    logic [1:0]  push;                  // One cycle push per queue
    logic [7:0]  next_rdata;
    logic        odd_q;                 // Parity of the current frame
    logic        next_odd_q;
    logic        cur_odd;               // Parity that applies to this bit
    logic [1:0]  q_valid;
    logic [15:0] q_data [2];
    logic [1:0]  q_pop;

    // Register writes and read mux
    always_comb begin
        next_frame_parity_select = frame_parity_select;
        next_slot_bit_mask       = slot_bit_mask;
        next_transmit_slot_map   = transmit_slot_map;
        next_receive_slot_map    = receive_slot_map;
        next_slot_choice_ch2     = slot_choice_ch2;
        next_slot_choice_ch3     = slot_choice_ch3;
        next_queue_low           = queue_low;
        push                     = 2'h0;
        next_rdata               = 8'h00;
        if (wr) begin
            unique case (addr)
                hdlc_sel_pkg::FRAME_PARITY_SELECT_OFS: next_frame_parity_select = wdata;
                hdlc_sel_pkg::CH1_SLOT_BIT_MASK_OFS:   next_slot_bit_mask[0]  = wdata;
                hdlc_sel_pkg::CH2_SLOT_BIT_MASK_OFS:   next_slot_bit_mask[1]  = wdata;
                hdlc_sel_pkg::CH3_SLOT_BIT_MASK_OFS:   next_slot_bit_mask[2]  = wdata;
                hdlc_sel_pkg::CH2_QUEUE_LOW_OFS:       next_queue_low[0]      = wdata;
                hdlc_sel_pkg::CH2_QUEUE_HIGH_OFS:      push[0]                = 1'b1;
                hdlc_sel_pkg::CH3_QUEUE_LOW_OFS:       next_queue_low[1]      = wdata;
                hdlc_sel_pkg::CH3_QUEUE_HIGH_OFS:      push[1]                = 1'b1;
                default: begin
                    // Slot maps are three bytes each, lowest slots first
                    for (int k = 0; k < hdlc_sel_pkg::MAP_BYTES; k++) begin
                        if (addr == hdlc_sel_pkg::TRANSMIT_SLOT_MAP_OFS + 8'(k)) begin
                            next_transmit_slot_map[8*k +: 8] = wdata;
                        end
                        if (addr == hdlc_sel_pkg::RECEIVE_SLOT_MAP_OFS + 8'(k)) begin
                            next_receive_slot_map[8*k +: 8] = wdata;
                        end
                        if (addr == hdlc_sel_pkg::SLOT_CHOICE_CH2_OFS + 8'(k)) begin
                            next_slot_choice_ch2[8*k +: 8] = wdata;
                        end
                        if (addr == hdlc_sel_pkg::SLOT_CHOICE_CH3_OFS + 8'(k)) begin
                            next_slot_choice_ch3[8*k +: 8] = wdata;
                        end
                    end
                end
            endcase
        end
        if (rd) begin
            // Queues are write only and read as zero, as does any unmapped address
            unique case (addr)
                hdlc_sel_pkg::FRAME_PARITY_SELECT_OFS: next_rdata = frame_parity_select;
                hdlc_sel_pkg::CH1_SLOT_BIT_MASK_OFS:   next_rdata = slot_bit_mask[0];
                hdlc_sel_pkg::CH2_SLOT_BIT_MASK_OFS:   next_rdata = slot_bit_mask[1];
                hdlc_sel_pkg::CH3_SLOT_BIT_MASK_OFS:   next_rdata = slot_bit_mask[2];
                hdlc_sel_pkg::QUEUE_STATUS_OFS: begin
                    next_rdata = {3'h0, odd_q, !queue_ready[1], !q_valid[1],
                                  !queue_ready[0], !q_valid[0]};
                end
                default: begin
                    for (int k = 0; k < hdlc_sel_pkg::MAP_BYTES; k++) begin
                        if (addr == hdlc_sel_pkg::TRANSMIT_SLOT_MAP_OFS + 8'(k)) begin
                            next_rdata = transmit_slot_map[8*k +: 8];
                        end
                        if (addr == hdlc_sel_pkg::RECEIVE_SLOT_MAP_OFS + 8'(k)) begin
                            next_rdata = receive_slot_map[8*k +: 8];
                        end
                        if (addr == hdlc_sel_pkg::SLOT_CHOICE_CH2_OFS + 8'(k)) begin
                            next_rdata = slot_choice_ch2[8*k +: 8];
                        end
                        if (addr == hdlc_sel_pkg::SLOT_CHOICE_CH3_OFS + 8'(k)) begin
                            next_rdata = slot_choice_ch3[8*k +: 8];
                        end
                    end
                end
            endcase
        end
    end

    // Register state; read data stands for one cycle only
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            frame_parity_select <= hdlc_sel_pkg::FRAME_PARITY_RST;
            for (int c = 0; c < hdlc_sel_pkg::NUM_CH; c++) begin
                slot_bit_mask[c] <= hdlc_sel_pkg::SLOT_BIT_MASK_RST;
            end
            transmit_slot_map <= hdlc_sel_pkg::SLOT_MAP_RST;
            receive_slot_map  <= hdlc_sel_pkg::SLOT_MAP_RST;
            slot_choice_ch2   <= hdlc_sel_pkg::SLOT_MAP_RST;
            slot_choice_ch3   <= hdlc_sel_pkg::SLOT_MAP_RST;
            queue_low[0]      <= hdlc_sel_pkg::QUEUE_BYTE_RST;
            queue_low[1]      <= hdlc_sel_pkg::QUEUE_BYTE_RST;
            rdata             <= 8'h00;
        end else begin
            frame_parity_select <= next_frame_parity_select;
            slot_bit_mask       <= next_slot_bit_mask;
            transmit_slot_map   <= next_transmit_slot_map;
            receive_slot_map    <= next_receive_slot_map;
            slot_choice_ch2     <= next_slot_choice_ch2;
            slot_choice_ch3     <= next_slot_choice_ch3;
            queue_low           <= next_queue_low;
            rdata               <= next_rdata;
        end
    end

    // ==========================================
    // Frame parity tracking
    always_comb begin
        // Multiframe start forces frame 1, each new frame flips parity
        cur_odd    = mf_start ? 1'b1 : (fr_start ? !odd_q : odd_q);
        next_odd_q = bit_strobe ? cur_odd : odd_q;
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            odd_q <= 1'b0;
        end else begin
            odd_q <= next_odd_q;
        end
    end

    // ==========================================
    // Channel ownership of the current bit
    logic [2:0] sel_rx;  // Bit belongs to channel, receive
    logic [2:0] sel_tx;  // Bit belongs to channel, transmit

    always_comb begin
        // One parity field and one mask per channel serve both directions
        sel_rx[0] = bit_strobe && owns(frame_parity_select[1:0], cur_odd, receive_slot_map,
                                       slot, slot_bit_mask[0], bit_pos);
        sel_tx[0] = bit_strobe && owns(frame_parity_select[1:0], cur_odd, transmit_slot_map,
                                       slot, slot_bit_mask[0], bit_pos);
        sel_rx[1] = bit_strobe && owns(frame_parity_select[3:2], cur_odd, slot_choice_ch2,
                                       slot, slot_bit_mask[1], bit_pos);
        sel_tx[1] = sel_rx[1];
        sel_rx[2] = bit_strobe && owns(frame_parity_select[5:4], cur_odd, slot_choice_ch3,
                                       slot, slot_bit_mask[2], bit_pos);
        sel_tx[2] = sel_rx[2];
    end

    assign ch1_tx_take = sel_tx[0];

    // ==========================================
    // Channel 2 and 3 queues and serialisers
    logic [15:0] shreg [2];       // Word being sent, LSB first
    logic [4:0]  bits_left [2];   // Bits still in the shift register
    logic [15:0] next_shreg [2];
    logic [4:0]  next_bits_left [2];
    logic [1:0]  ser_bit;         // Bit offered to the line

    for (genvar j = 0; j < 2; j++) begin : g_queue
        tx_word_queue #(
            .WIDTH (hdlc_sel_pkg::QUEUE_WORD_W),
            .DEPTH (QUEUE_DEPTH)
        ) u_queue (
            .clock     (clock),
            .resetn    (resetn),
            .in_valid  (push[j]),
            .in_ready  (queue_ready[j]),
            .in_data   ({wdata, queue_low[j]}),
            .out_valid (q_valid[j]),
            .out_ready (q_pop[j]),
            .out_data  (q_data[j])
        );

        // Shift out one bit per owned line bit; idle ones when the queue is dry
        always_comb begin
            next_shreg[j]     = shreg[j];
            next_bits_left[j] = bits_left[j];
            q_pop[j]          = 1'b0;
            ser_bit[j]        = 1'b1;
            if (sel_tx[j+1]) begin
                if (bits_left[j] != 5'h00) begin
                    ser_bit[j]        = shreg[j][0];
                    next_shreg[j]     = {1'b0, shreg[j][15:1]};
                    next_bits_left[j] = bits_left[j] - 5'h01;
                end else if (q_valid[j]) begin
                    q_pop[j]          = 1'b1;
                    ser_bit[j]        = q_data[j][0];
                    next_shreg[j]     = {1'b0, q_data[j][15:1]};
                    next_bits_left[j] = 5'(hdlc_sel_pkg::QUEUE_BITS);
                end
            end
        end

        always_ff @(posedge clock or negedge resetn) begin
            if (!resetn) begin
                shreg[j]     <= hdlc_sel_pkg::QUEUE_WORD_RST;
                bits_left[j] <= 5'h00;
            end else begin
                shreg[j]     <= next_shreg[j];
                bits_left[j] <= next_bits_left[j];
            end
        end
    end

    // ==========================================
    // Line outputs, registered
    logic [2:0] next_rx_valid;
    logic [2:0] next_rx_data;
    logic       next_tx_line_valid;
    logic       next_tx_line_bit;

    always_comb begin
        next_rx_valid      = sel_rx;
        next_rx_data       = sel_rx & {3{line_rx_bit}};
        next_tx_line_valid = |sel_tx;
        // Disjoint channels assumed; overlap resolves to the lowest channel
        next_tx_line_bit   = sel_tx[0] ? ch1_tx_bit :
                             sel_tx[1] ? ser_bit[0] :
                             sel_tx[2] ? ser_bit[1] : 1'b1;
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            rx_valid      <= 3'h0;
            rx_data       <= 3'h0;
            tx_line_valid <= 1'b0;
            tx_line_bit   <= 1'b1;
        end else begin
            rx_valid      <= next_rx_valid;
            rx_data       <= next_rx_data;
            tx_line_valid <= next_tx_line_valid;
            tx_line_bit   <= next_tx_line_bit;
        end
    end

    // ==========================================
    // Checks
    logic cfg_written; // Helper: any register written since reset
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            cfg_written <= 1'b0;
        end else if (wr) begin
            cfg_written <= 1'b1;
        end
    end

    sequence owned_bit_s(int c);
        bit_strobe && sel_rx[c];
    endsequence

    reset_values_a: assert property (@(posedge clock) disable iff (!resetn)
        !cfg_written |-> frame_parity_select == 8'h00 && slot_bit_mask[0] == 8'hff
                     && slot_bit_mask[1] == 8'hff && slot_bit_mask[2] == 8'hff)
        else $error("configuration not at reset values");
    mf_odd_a: assert property (@(posedge clock) disable iff (!resetn)
        bit_strobe && mf_start |=> odd_q)
        else $error("multiframe did not start on an odd frame");
    frame_flip_a: assert property (@(posedge clock) disable iff (!resetn)
        bit_strobe && fr_start && !mf_start |=> odd_q != $past(odd_q))
        else $error("frame parity did not alternate");
    ch1_map_a: assert property (@(posedge clock) disable iff (!resetn)
        bit_strobe && slot < 5'd24 && !transmit_slot_map[slot] |-> !ch1_tx_take)
        else $error("channel 1 took a bit outside its transmit map");

    for (genvar c = 0; c < 3; c++) begin : g_checks
        par_odd_a: assert property (@(posedge clock) disable iff (!resetn)
            owned_bit_s(c) ##0 frame_parity_select[2*c +: 2] == 2'h1 |-> cur_odd)
            else $error("odd-only channel used an even frame");
        par_even_a: assert property (@(posedge clock) disable iff (!resetn)
            owned_bit_s(c) ##0 frame_parity_select[2*c +: 2] == 2'h2 |-> !cur_odd)
            else $error("even-only channel used an odd frame");
        mask_excl_a: assert property (@(posedge clock) disable iff (!resetn)
            bit_strobe && !slot_bit_mask[c][bit_pos] |=> !rx_valid[c])
            else $error("masked bit position reached a channel");
        rx_out_a: assert property (@(posedge clock) disable iff (!resetn)
            owned_bit_s(c) |=> rx_valid[c] && rx_data[c] == $past(line_rx_bit))
            else $error("owned bit not delivered next cycle");
    end
    shared_dir_a: assert property (@(posedge clock) disable iff (!resetn)
        bit_strobe && (|sel_rx[2:1]) |=> tx_line_valid)
        else $error("channel 2/3 receive bit not also sent");
endmodule

`default_nettype wire

// file: include/hdlc_sel_pkg.sv
// Constants and register map for HDLC frame, slot and bit selection
//
// Behaviour
// - Parity code 00 both, 01 odd, 10 even
// - Frames counted from one; odd then even
// - Multiframe starts odd, ends even
// - Parity choice shared by receive and transmit
// - Parity select register resets to zero
// - Mask bit x enables bit position x
// - Each slot bit mask resets to ff
// - Bit mask shared by receive and transmit
// - Channel one has separate receive/transmit maps
// - Channels two, three use one shared map
// - Sixteen-bit transmit queues, reset to zero

package hdlc_sel_pkg;

    // ==========================================
    // Register offsets (byte addresses)
    localparam logic [7:0] FRAME_PARITY_SELECT_OFS = 8'ha0; // Parity codes, 2 bits per channel
    localparam logic [7:0] CH1_SLOT_BIT_MASK_OFS   = 8'ha1; // Channel 1 bit positions
    localparam logic [7:0] CH2_SLOT_BIT_MASK_OFS   = 8'ha2; // Channel 2 bit positions
    localparam logic [7:0] CH3_SLOT_BIT_MASK_OFS   = 8'ha3; // Channel 3 bit positions
    localparam logic [7:0] TRANSMIT_SLOT_MAP_OFS   = 8'ha4; // Channel 1 transmit map, 3 bytes
    localparam logic [7:0] RECEIVE_SLOT_MAP_OFS    = 8'ha7; // Channel 1 receive map, 3 bytes
    localparam logic [7:0] SLOT_CHOICE_CH2_OFS     = 8'haa; // Channel 2 map, 3 bytes
    localparam logic [7:0] SLOT_CHOICE_CH3_OFS     = 8'had; // Channel 3 map, 3 bytes
    localparam logic [7:0] CH2_QUEUE_LOW_OFS       = 8'hb0; // Channel 2 queue low byte
    localparam logic [7:0] CH2_QUEUE_HIGH_OFS      = 8'hb1; // Channel 2 queue high byte, pushes
    localparam logic [7:0] CH3_QUEUE_LOW_OFS       = 8'hb2; // Channel 3 queue low byte
    localparam logic [7:0] CH3_QUEUE_HIGH_OFS      = 8'hb3; // Channel 3 queue high byte, pushes
    localparam logic [7:0] QUEUE_STATUS_OFS        = 8'hb4; // Queue and frame state, read only

    // ==========================================
    // Field layout and codes
    localparam int         PARITY_W     = 2;      // Width of one parity field
    localparam logic [1:0] PARITY_BOTH  = 2'h0;   // Even and odd frames
    localparam logic [1:0] PARITY_ODD   = 2'h1;   // Odd frames only
    localparam logic [1:0] PARITY_EVEN  = 2'h2;   // Even frames only
    localparam int         NUM_CH       = 3;      // HDLC channels
    localparam int         NUM_SLOTS    = 24;     // Time slots in a frame
    localparam int         MAP_BYTES    = 3;      // Bytes per slot map
    localparam int         QUEUE_WORD_W = 16;     // Transmit queue word width
    localparam int         QUEUE_BITS   = 15;     // Bits left after a word is loaded

    // ==========================================
    // Values after reset
    localparam logic [7:0]  FRAME_PARITY_RST = 8'h00;  // All frames used
    localparam logic [7:0]  SLOT_BIT_MASK_RST = 8'hff; // All bit positions used
    localparam logic [23:0] SLOT_MAP_RST      = 24'h000000; // No slot chosen
    localparam logic [7:0]  QUEUE_BYTE_RST    = 8'h00; // Queue word holding byte
    localparam logic [15:0] QUEUE_WORD_RST    = 16'h0000; // Serialiser word

endpackage

// file: test/line_source.sv
// Framer-side model: a stream of line bits in four-frame multiframes
`timescale 1ns/1ps
`default_nettype none
module line_source (
    input  wire logic clock,
    input  wire logic resetn,
    output logic      mf_start,
    output logic      fr_start,
    output logic      bit_strobe,
    output logic [4:0] slot,
    output logic [2:0] bit_pos,
    output logic      line_rx_bit,
    output logic      ch1_tx_bit
);
    logic [1:0] frame; // Frame within the multiframe
    // ==========================================
    // Bits come with random gaps, so prompt and slow framers are both seen
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            {frame, slot, bit_pos, bit_strobe, line_rx_bit, ch1_tx_bit} <= '0;
        end else begin
            bit_strobe <= ($urandom % 4) != 0;
            line_rx_bit <= 1'($urandom);
            ch1_tx_bit <= 1'($urandom);
            if (bit_strobe) begin
                bit_pos <= bit_pos + 3'h1;
                if (bit_pos == 3'h7) slot <= (slot == 5'h17) ? 5'h00 : slot + 5'h01;
                if (bit_pos == 3'h7 && slot == 5'h17) frame <= frame + 2'h1;
            end
        end
    end
    assign fr_start = bit_strobe && slot == 5'h00 && bit_pos == 3'h0;
    assign mf_start = fr_start && frame == 2'h0;
endmodule
`default_nettype wire

// file: test/tb_hdlc_slot_bit_frame_select.sv
// Self-checking bench for the HDLC frame, slot and bit selection block
`timescale 1ns/1ps
`default_nettype none
module tb_hdlc_slot_bit_frame_select;
    logic clock, resetn, wr, rd, mf_start, fr_start, bit_strobe, line_rx_bit, ch1_tx_bit;
    logic ch1_tx_take, tx_line_valid, tx_line_bit, e_tv, e_tb, chk, odd_f;
    logic [7:0] addr, wdata, rdata;
    logic [4:0] slot;
    logic [2:0] bit_pos, rx_valid, rx_data, e_rv, e_rd;
    logic [1:0] queue_ready;
    logic [1:0] par [3];  // Model parity codes
    logic [7:0] msk [3];  // Model bit masks
    logic [23:0] map [4]; // Model maps: ch1 tx, ch1 rx, ch2, ch3
    logic [3:0] o;
    bit q [2][$];         // Queued bits, ch2 and ch3
    int mismatches, samples_checked, n, b;
    hdlc_slot_bit_frame_select #(.QUEUE_DEPTH(4)) DUT (.clock, .resetn, .addr, .wdata, .wr,
        .rd, .rdata, .mf_start, .fr_start, .bit_strobe, .slot, .bit_pos, .line_rx_bit,
        .ch1_tx_bit, .ch1_tx_take, .rx_valid, .rx_data, .tx_line_valid, .tx_line_bit,
        .queue_ready);
    line_source src (.clock, .resetn, .mf_start, .fr_start, .bit_strobe, .slot, .bit_pos,
        .line_rx_bit, .ch1_tx_bit);
    function automatic logic own(int c, int m, logic odd);
        return bit_strobe && map[m][slot] && msk[c][bit_pos] &&
            (par[c] == 2'h1 ? odd : (par[c] == 2'h2 ? !odd : 1'b1));
    endfunction
    // Odd at the multiframe start, toggling every frame
    function automatic logic odd_now();
        return (bit_strobe && mf_start) || (odd_f ^ (bit_strobe && fr_start));
    endfunction
    function automatic bit pop(int c);
        return q[c].size() > 0 ? q[c].pop_front() : 1'b1;
    endfunction
    task automatic cmp(string nm, logic [7:0] s, logic [7:0] e);
        samples_checked++;
        if (s !== e) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", nm, e, s);
        end
    endtask
    // ==========================================
    // Register bus; the model copy lands on the same edge as the design's
    task automatic wreg(logic [7:0] a, logic [7:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clock);
        wr <= 1'b0;
        if (a == 8'ha0) par <= '{d[1:0], d[3:2], d[5:4]};
        else if (a inside {[8'ha1:8'ha3]}) msk[a - 8'ha1] <= d;
        else if (a inside {[8'ha4:8'haf]}) map[(a - 8'ha4) / 3][(a - 8'ha4) % 3 * 8 +: 8] <= d;
        @(posedge clock);
    endtask
    task automatic rdchk(logic [7:0] a, logic [7:0] e, logic [7:0] m);
        addr <= a;
        rd <= 1'b1;
        @(posedge clock);
        rd <= 1'b0;
        @(negedge clock);
        cmp("rdata", rdata & m, e);
        @(posedge clock);
    endtask
    task automatic push(int c, logic [15:0] w);
        logic ok;
        wreg(8'hb0 + 8'(2 * c), w[7:0]);
        ok = queue_ready[c];
        wreg(8'hb1 + 8'(2 * c), w[15:8]);
        if (ok) for (int i = 0; i < 16; i++) q[c].push_back(w[i]);
    endtask
    // Channel maps on disjoint slots; ch2/ch3 off while words are queued
    task automatic wmaps(bit on);
        logic [23:0] v;
        for (int m = 0; m < 4; m++) begin
            v = (m < 2 || on) ? 24'h1 << (b + 6 * m) : 24'h0;
            for (int k = 0; k < 3; k++) wreg(8'ha4 + 8'(3 * m + k), v[8 * k +: 8]);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // ==========================================
    // Model of the line outputs, compared in mid-cycle
    always @(posedge clock) begin
        odd_f = odd_now();
        o = {own(2, 3, odd_f), own(1, 2, odd_f), own(0, 1, odd_f), own(0, 0, odd_f)};
        e_rv = o[3:1];
        e_rd = e_rv & {3{line_rx_bit}};
        e_tv = o[0] | o[2] | o[3];
        e_tb = o[0] ? ch1_tx_bit : (o[2] ? pop(0) : (o[3] ? pop(1) : 1'b1));
    end
    always @(negedge clock) if (chk) begin
        cmp("rx_valid", 8'(rx_valid), 8'(e_rv));
        cmp("rx_data", 8'(rx_data), 8'(e_rd));
        cmp("tx_line_valid", 8'(tx_line_valid), 8'(e_tv));
        cmp("tx_line_bit", 8'(tx_line_bit), 8'(e_tb));
        cmp("ch1_tx_take", 8'(ch1_tx_take), 8'(own(0, 0, odd_now())));
    end
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    initial begin
        #1000000;
        mismatches++;
        end_sim();
    end
    initial begin
        {resetn, addr, wdata, wr, rd, chk, odd_f} = '0;
        par = '{default: 2'h0};
        msk = '{default: 8'hff};
        map = '{default: 24'h0};
        void'($urandom(32'hf5c626e2));
        repeat (8) @(posedge clock);
        resetn <= 1'b1;
        chk <= 1'b1;
        @(posedge clock);
        rdchk(8'ha0, 8'h00, 8'hff);
        for (int a = 1; a < 4; a++) rdchk(8'ha0 + 8'(a), 8'hff, 8'hff);
        rdchk(8'h10, 8'h00, 8'hff);
        rdchk(8'hb4, 8'h05, 8'h0f);
        $display("reset values done");
        for (int p = 0; p < 4; p++) begin
            b = $urandom % 6;
            wmaps(1'b0);
            push(0, 16'($urandom));
            push(1, 16'($urandom));
            n = 1;
            while (p == 0 && queue_ready[1] === 1'b1 && n < 100) begin
                push(1, 16'($urandom));
                n++;
            end
            if (p == 0) cmp("queue depth", 8'(n >= 4), 8'h01);
            if (p == 0) begin
                push(1, 16'hffff);
                rdchk(8'hb4, 8'h08, 8'h0f);
            end
            wreg(8'ha0, {2'h0, 2'(p + 2), 2'(p + 1), 2'(p)});
            for (int c = 0; c < 3; c++) wreg(8'ha1 + 8'(c), 8'($urandom));
            rdchk(8'ha1 + 8'(p % 3), msk[p % 3], 8'hff);
            wmaps(1'b1);
            repeat (1600) @(posedge clock);
            $display("parity code %0d done", p);
        end
        end_sim();
    end
endmodule
`default_nettype wire
